/* pce_pkg.sv */
// Shared constants for the port class and detect event flag block
package pce_pkg;
	localparam int         NPORT      = 4;      // Ports served
	localparam int         ADDR_W     = 8;      // Register address width
	localparam int         DATA_W     = 8;      // Register data width
	localparam int         RES_W      = 4;      // Width of one result code
	localparam int         DET_LSB    = 0;      // Detection-complete flags, bits 3..0
	localparam int         CLS_LSB    = 4;      // Class-complete flags, bits 7..4
	localparam logic [7:0] OFF_VIEW   = 8'h04;  // Read-only view of the flags
	localparam logic [7:0] OFF_CLEAR  = 8'h05;  // Clear-on-read view of the flags
	localparam logic [7:0] FLAGS_RST  = 8'h00;  // Flags after reset
	localparam logic [3:0] RES_RST    = 4'h0;   // Result codes after reset
	localparam logic [3:0] VALID_SIG  = 4'h4;   // Detection code for a valid signature
	localparam logic [3:0] CHK_RST    = 4'h0;   // Pair connection-check fields after reset
endpackage

/* pce_port_track.sv */
// One port: holds its results and decides when its event flags set
`timescale 1ns/10ps
module pce_port_track
	import pce_pkg::*;
(
	input  wire logic             clk,          // System clock
	input  wire logic             rstn,         // Synchronous reset, active low
	input  wire logic             det_done,     // Detection finished, one-cycle pulse
	input  wire logic [RES_W-1:0] det_result,   // New detection result
	input  wire logic             cls_done,     // Classification finished, one-cycle pulse
	input  wire logic [RES_W-1:0] cls_result,   // New classification result
	input  wire logic             det_chg_only, // Detection flag only on a changed result
	input  wire logic             cls_chg_only, // Class flag only on a changed result
	output logic                  det_set,      // Detection flag event
	output logic                  cls_set,      // Class flag event
	output logic [RES_W-1:0]      det_res,      // Held detection result
	output logic [RES_W-1:0]      cls_res       // Held classification result
);
	typedef struct packed {
		logic [RES_W-1:0] det;
		logic [RES_W-1:0] cls;
	} pce_trk_t;

	pce_trk_t s_q, s_d;

	// Event decode; the change-only options trim repeated identical results
	always_comb begin
		det_set = det_done && (!det_chg_only || det_result != s_q.det);
		cls_set = cls_done && (!cls_chg_only || cls_result != s_q.cls);
	end

	// Result update; a class result implies the signature was good
	always_comb begin
		s_d = s_q;
		if (det_done)
			s_d.det = det_result;
		if (cls_done) begin
			s_d.cls = cls_result;
			s_d.det = VALID_SIG;
		end
		if (!rstn) begin
			s_d.det = RES_RST;
			s_d.cls = RES_RST;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign det_res = s_q.det;
	assign cls_res = s_q.cls;

	chk_chg_only_quiet: assert property (@(posedge clk) disable iff (!rstn)
		det_chg_only && det_done && det_result == s_q.det |-> !det_set)
		else $error("detection flag set on unchanged result");

	chk_class_valid_sig: assert property (@(posedge clk) disable iff (!rstn)
		cls_done |=> s_q.det == VALID_SIG && s_q.cls == $past(cls_result))
		else $error("class result without valid signature");
endmodule // pce_port_track

/* pce_event_flags.sv */
// Per-port class and detect event flags with read-only and clear-on-read views
// Notes on behaviour
// - Class-complete flags in bits 7..4, port four highest
// - Detection flags bits 3..0 drive detection summary
// - Any class flag drives classification summary bit
// - Change-only option: detection flag only on change
// - Class result implies valid signature reported
// - Four-pair ports update pair connection-check field
// - Offset 0x04 reads; offset 0x05 reads then clears
// - Reset clears all eight flags
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module pce_event_flags
	import pce_pkg::*;
(
	input  wire logic                     CLK_SYS,       // System clock, 25 MHz
	input  wire logic                     RSTN,          // Synchronous reset, active low
	input  wire logic [pce_pkg::ADDR_W-1:0] ADDR,        // Register address
	input  wire logic [pce_pkg::DATA_W-1:0] WR_DATA,     // Write data, no writable register here
	input  wire logic                     WR_STB,        // Write strobe, ignored
	input  wire logic                     RD_STB,        // Read strobe
	output logic [pce_pkg::DATA_W-1:0]    RD_DATA,       // Read data, cycle after strobe
	input  wire logic [pce_pkg::NPORT-1:0] DET_DONE,     // Detection finished per port
	input  wire logic [4*pce_pkg::RES_W-1:0] DET_RESULT, // Detection results, port 1 lowest
	input  wire logic [pce_pkg::NPORT-1:0] CLS_DONE,     // Classification finished per port
	input  wire logic [4*pce_pkg::RES_W-1:0] CLS_RESULT, // Class results, port 1 lowest
	input  wire logic                     DET_CHG_ONLY,  // Detection flag on change only
	input  wire logic                     CLS_CHG_ONLY,  // Class flag on change only
	input  wire logic [1:0]               FOURPAIR,      // Pair of ports 1-2, 3-4 in four-pair use
	input  wire logic [3:0]               PAIR_CHECK_IN, // Connection-check results, 2 bits per pair
	output logic [3:0]                    PAIR_CHECK,    // Held connection-check fields
	output logic [4*2*pce_pkg::RES_W-1:0] PORT_RESULT,   // Per port {class, detection}
	output logic                          DET_SUMMARY,   // Detection summary bit of interrupt reg
	output logic                          CLS_SUMMARY    // Classification summary bit
);
	import pce_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] rd_data;
		logic              det_sum;
		logic              cls_sum;
		logic [3:0]        chk;
	} pce_top_t;

	pce_top_t s_q, s_d;
	logic [NPORT-1:0] det_set, cls_set;
	logic [DATA_W-1:0] set_v, clr_v;

	// Register decode; one place so the read-data and clear decodes cannot drift apart
	function automatic logic hits(input logic stb, input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return stb && (a == off);
	endfunction

	// Per-port result holders and event filters
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		pce_port_track u_trk (
			.clk          (CLK_SYS),
			.rstn         (RSTN),
			.det_done     (DET_DONE[p]),
			.det_result   (DET_RESULT[p*RES_W +: RES_W]),
			.cls_done     (CLS_DONE[p]),
			.cls_result   (CLS_RESULT[p*RES_W +: RES_W]),
			.det_chg_only (DET_CHG_ONLY),
			.cls_chg_only (CLS_CHG_ONLY),
			.det_set      (det_set[p]),
			.cls_set      (cls_set[p]),
			.det_res      (PORT_RESULT[p*2*RES_W +: RES_W]),
			.cls_res      (PORT_RESULT[p*2*RES_W+RES_W +: RES_W])
		);
	end

	// Next state; set beats clear so a racing event survives the read
	always_comb begin
		s_d = s_q;
		set_v = '0;
		set_v[CLS_LSB +: NPORT] = cls_set;
		set_v[DET_LSB +: NPORT] = det_set;
		clr_v = hits(RD_STB, ADDR, OFF_CLEAR) ? s_q.flags : FLAGS_RST;
		s_d.flags = (s_q.flags & ~clr_v) | set_v;
		// Both views read the same storage; data is the value before any clear
		s_d.rd_data = (hits(RD_STB, ADDR, OFF_VIEW) || hits(RD_STB, ADDR, OFF_CLEAR)) ? s_q.flags : 8'h00;
		s_d.det_sum = |s_d.flags[DET_LSB +: NPORT];
		s_d.cls_sum = |s_d.flags[CLS_LSB +: NPORT];
		// Pair fields follow any result produced on either port of a four-pair group
		for (int k = 0; k < 2; k++) begin
			if (FOURPAIR[k] && |(DET_DONE[2*k +: 2] | CLS_DONE[2*k +: 2]))
				s_d.chk[2*k +: 2] = PAIR_CHECK_IN[2*k +: 2];
		end
		if (!RSTN) begin
			s_d.flags   = FLAGS_RST;
			s_d.rd_data = 8'h00;
			s_d.det_sum = 1'b0;
			s_d.cls_sum = 1'b0;
			s_d.chk     = CHK_RST;
		end
	end

	// State register
	always_ff @(posedge CLK_SYS) begin
		s_q <= s_d;
	end

	assign RD_DATA     = s_q.rd_data;
	assign DET_SUMMARY = s_q.det_sum;
	assign CLS_SUMMARY = s_q.cls_sum;
	assign PAIR_CHECK  = s_q.chk;

	chk_class_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		|cls_set |=> (s_q.flags[7:4] & $past(cls_set)) == $past(cls_set))
		else $error("class event did not set its flag");

	chk_det_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		|det_set |=> (s_q.flags[3:0] & $past(det_set)) == $past(det_set))
		else $error("detection event did not set its flag");

	chk_det_summary: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		DET_SUMMARY == |s_q.flags[3:0])
		else $error("detection summary disagrees with flags");

	chk_cls_summary: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		CLS_SUMMARY == |s_q.flags[7:4])
		else $error("class summary disagrees with flags");

	chk_pair_update: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		FOURPAIR[0] && |(DET_DONE[1:0] | CLS_DONE[1:0]) |=> PAIR_CHECK[1:0] == $past(PAIR_CHECK_IN[1:0]))
		else $error("pair check field not updated");

	chk_view_keeps: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		RD_STB && ADDR == OFF_VIEW |=> RD_DATA == $past(s_q.flags) && (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
		else $error("view read wrong or altered flags");

	chk_reset_clear: assert property (@(posedge CLK_SYS)
		!RSTN |=> s_q.flags == 8'h00 && !DET_SUMMARY && !CLS_SUMMARY)
		else $error("flags not cleared by reset");

	chk_clear_keeps_new: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		RD_STB && ADDR == OFF_CLEAR |=> RD_DATA == $past(s_q.flags) && s_q.flags == $past(set_v))
		else $error("clearing read lost an event or kept old flags");

	// Read data stands for one cycle only, so a late sampler sees zero, not stale flags
	chk_idle_rd_zero: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!RD_STB |=> RD_DATA == 8'h00)
		else $error("read data not zero outside a read");

	// Unmapped offsets answer zero and leave the flags alone
	chk_unmapped_zero: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		RD_STB && ADDR != OFF_VIEW && ADDR != OFF_CLEAR |=> RD_DATA == 8'h00)
		else $error("unmapped read returned data");

	// Second pair group follows the same update rule as the first
	chk_pair1_update: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		FOURPAIR[1] && |(DET_DONE[3:2] | CLS_DONE[3:2]) |=> PAIR_CHECK[3:2] == $past(PAIR_CHECK_IN[3:2]))
		else $error("second pair check field not updated");

	// Without a result on the group the held field must not move
	chk_pair_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!(FOURPAIR[0] && |(DET_DONE[1:0] | CLS_DONE[1:0])) |=> $stable(PAIR_CHECK[1:0]))
		else $error("pair check field changed without a result");

	// Only a clearing read or an event may change the flags; writes have no effect
	chk_flags_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!(RD_STB && ADDR == OFF_CLEAR) && set_v == 8'h00 |=> $stable(s_q.flags))
		else $error("flags changed without event or clearing read");

	// Any class event raises the class summary in the next cycle
	chk_cls_sum_rise: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		|cls_set |=> CLS_SUMMARY)
		else $error("class summary not raised by event");

	// Any detection event raises the detection summary in the next cycle
	chk_det_sum_rise: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		|det_set |=> DET_SUMMARY)
		else $error("detection summary not raised by event");

	// Port four owns the top bit of the class field
	chk_port4_bit: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		cls_set[3] |=> s_q.flags[7])
		else $error("port four class event not in bit 7");
endmodule // pce_event_flags

/* pce_engine_model.sv */
// Behavioural detection and classification engines driving the flag block
`timescale 1ns/10ps
module pce_engine_model
	import pce_pkg::*;
(
	input  wire logic                 clk,        // System clock
	output logic [NPORT-1:0]          det_done,   // Detection finished pulses
	output logic [NPORT*RES_W-1:0]    det_result, // Detection results
	output logic [NPORT-1:0]          cls_done,   // Class finished pulses
	output logic [NPORT*RES_W-1:0]    cls_result  // Class results
);
	// Quiet start so nothing fires during reset
	initial begin
		det_done = '0;
		cls_done = '0;
		det_result = '0;
		cls_result = '0;
	end
	// One-cycle completion; results go stale afterwards so only the pulse cycle counts
	task automatic fire(input logic cls, input int p, input logic [RES_W-1:0] r);
		@(posedge clk);
		if (cls) begin
			cls_done[p] <= 1'b1;
			cls_result[p*RES_W +: RES_W] <= r;
		end else begin
			det_done[p] <= 1'b1;
			det_result[p*RES_W +: RES_W] <= r;
		end
		@(posedge clk);
		det_done <= '0;
		cls_done <= '0;
		det_result <= ~det_result; // Stale data, not last value
		cls_result <= ~cls_result;
	endtask
endmodule // pce_engine_model

/* pce_testbench.sv */
// Self-checking bench for the class and detect event flag block
`timescale 1ns/10ps
module testbench;
	import pce_pkg::*;
	logic        CLK_SYS, RSTN, WR_STB, RD_STB, DET_SUMMARY, CLS_SUMMARY, DET_CHG_ONLY, CLS_CHG_ONLY;
	logic [7:0]  ADDR, WR_DATA, RD_DATA, d;
	logic [3:0]  DET_DONE, CLS_DONE, PAIR_CHECK_IN, PAIR_CHECK;
	logic [1:0]  FOURPAIR;
	logic [15:0] DET_RESULT, CLS_RESULT;
	logic [31:0] PORT_RESULT;
	int          num_errors = 0;
	int          cmp_count = 0;
	pce_event_flags dut_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
		.RD_STB(RD_STB), .RD_DATA(RD_DATA), .DET_DONE(DET_DONE), .DET_RESULT(DET_RESULT), .CLS_DONE(CLS_DONE),
		.CLS_RESULT(CLS_RESULT), .DET_CHG_ONLY(DET_CHG_ONLY), .CLS_CHG_ONLY(CLS_CHG_ONLY), .FOURPAIR(FOURPAIR),
		.PAIR_CHECK_IN(PAIR_CHECK_IN), .PAIR_CHECK(PAIR_CHECK), .PORT_RESULT(PORT_RESULT),
		.DET_SUMMARY(DET_SUMMARY), .CLS_SUMMARY(CLS_SUMMARY));
	pce_engine_model eng_u (.clk(CLK_SYS), .det_done(DET_DONE), .det_result(DET_RESULT), .cls_done(CLS_DONE),
		.cls_result(CLS_RESULT));
	// 25 MHz clock
	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read strobe for one cycle; data is only valid in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge CLK_SYS);
		RD_STB <= 1'b1;
		ADDR <= a;
		@(posedge CLK_SYS);
		RD_STB <= 1'b0;
		#1 v = RD_DATA;
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#200000 num_errors++;
		stop_test();
	end
	initial begin
		{RSTN, WR_STB, RD_STB, DET_CHG_ONLY, CLS_CHG_ONLY, ADDR, WR_DATA, FOURPAIR, PAIR_CHECK_IN} = '0;
		repeat (3) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		rd(OFF_VIEW, d); chk(d, 8'h00);
		chk({DET_SUMMARY, CLS_SUMMARY}, 2'b00);
		$display("test reset done");
		@(posedge CLK_SYS);
		FOURPAIR <= 2'b11;
		PAIR_CHECK_IN <= 4'h6;
		eng_u.fire(1'b1, 0, 4'h3);
		#1 chk(PORT_RESULT[7:0], 8'h34);
		chk(PAIR_CHECK[1:0], 2'b10);
		chk({DET_SUMMARY, CLS_SUMMARY}, 2'b01);
		rd(OFF_VIEW, d); chk(d, 8'h10);
		eng_u.fire(1'b0, 3, 4'h4);
		#1 chk(PORT_RESULT[31:24], 8'h04);
		chk(PAIR_CHECK, 4'h6);
		chk(DET_SUMMARY, 1'b1);
		@(posedge CLK_SYS);
		WR_STB <= 1'b1;
		ADDR <= OFF_VIEW;
		WR_DATA <= 8'hff;
		@(posedge CLK_SYS);
		WR_STB <= 1'b0;
		rd(OFF_VIEW, d); chk(d, 8'h18);
		$display("test events done");
		rd(OFF_CLEAR, d); chk(d, 8'h18);
		rd(OFF_VIEW, d); chk(d, 8'h00);
		chk({DET_SUMMARY, CLS_SUMMARY}, 2'b00);
		// Event lands in the same cycle as the clearing read
		fork
			eng_u.fire(1'b0, 1, 4'h2);
			rd(OFF_CLEAR, d);
		join
		chk(d, 8'h00);
		rd(OFF_VIEW, d); chk(d, 8'h02);
		rd(8'h06, d); chk(d, 8'h00);
		rd(OFF_CLEAR, d); chk(d, 8'h02);
		$display("test clear on read done");
		@(posedge CLK_SYS);
		DET_CHG_ONLY <= 1'b1;
		CLS_CHG_ONLY <= 1'b1;
		eng_u.fire(1'b0, 3, 4'h4);
		eng_u.fire(1'b1, 0, 4'h3);
		rd(OFF_VIEW, d); chk(d, 8'h00);
		eng_u.fire(1'b0, 3, 4'h1);
		rd(OFF_VIEW, d); chk(d, 8'h08);
		$display("test change only done");
		stop_test();
	end
endmodule // testbench
